//--- rtl/ast_transmitter.sv
// Asynchronous serial transmitter with its APB register slave
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Operation
// [R1] Line idles at mark between characters
// [R2] Start, eight or nine data, stop
// [R3] Every bit lasts one baud period
// [R4] Data goes least significant bit first
// [R5] Baud timing from selectable 8/16-bit generator
// [R6] No hardware parity; software uses ninth bit
// [R7] Sends only when enabled, asynchronous, port on
// [R8] Port enable makes pin a driven output
// [R9] Disabled transmitter releases the pin
// [R10] Holding write loads idle shifter at once
// [R11] Busy shifter: load within one instruction cycle
// [R12] Polarity bit inverts whole line including idle
// [R13] Polarity acts in asynchronous mode only; here it also inverts the idle pin level in synchronous mode
// [R14] Empty flag clear only while holding full; here it is also clear while the transmitter is disabled
// [R15] Empty flag valid by second instruction cycle
// [R16] Empty flag read-only, set by enable
// [R17] Request needs flag and three enables
// [R18] Shifter-empty status clear while shifting
// [R19] Nine-bit mode sends stored ninth bit last
// [R20] Software writes ninth bit before low byte
// [R21] Ninth bit one marks an address
// [R22] Software enables interrupt only while data remains
// [R23] Keep mark level until next character
// ----------------------------------------------------------------------
module ast_transmitter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire ast_pkg::ast_apb_req_t apb_i,
    output var ast_pkg::ast_apb_rsp_t apb_o,
    // Transmit pin
    output var logic transmit_clock_pin_o,
    output var logic transmit_clock_pin_oe_o,
    // Interrupt request
    output var logic tx_irq_o
);
    import ast_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_b;
    logic rst_b;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    // ------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------
    ast_state_t st;
    ast_state_t next_st;
    logic tx_en;
    logic active;
    logic transmit_empty_flag;
    logic shifter_empty_status;
    logic access;
    logic commit;
    logic tick;
    logic last_data;
    logic [6:0] pre_max;
    logic [15:0] divisor;
    logic [7:0] rd_byte;

    assign tx_en = st.tx_ctrl[TXC_EN];
    // Synchronous mode is not built here, so it simply blocks sending
    assign active = tx_en & ~st.tx_ctrl[TXC_SYNC] & st.serial_port_enable; // [R7] [R13]
    assign transmit_empty_flag = tx_en & ~st.hold_full; // [R14] [R15] [R16]
    assign shifter_empty_status = (st.fsm == ST_IDLE); // [R18]
    assign pre_max = ast_prescale(st.wide, st.tx_ctrl[TXC_HIGH_SPEED]); // [R5]
    assign divisor = ast_divisor(st.wide, st.div_lo, st.div_hi); // [R5]
    assign tick = (st.fsm != ST_IDLE) && (st.pre_cnt == pre_max - 7'h01)
                  && (st.div_cnt == 16'h0000); // [R3]
    assign last_data = (st.bit_cnt == (st.nine_frame ? LAST_BIT_NINE : LAST_BIT_EIGHT));
    assign access = apb_i.psel & apb_i.penable & ~st.rsp.pready;
    // A write lands only at the edge where the master sees pready high
    assign commit = apb_i.psel & apb_i.penable & st.rsp.pready & apb_i.pwrite
                    & ~st.rsp.pslverr & apb_i.pstrb[0];

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        case (apb_i.paddr)
            ADDR_TX_CTRL: begin
                rd_byte = st.tx_ctrl;
                rd_byte[TXC_SHIFT_EMPTY] = shifter_empty_status; // [R18]
            end
            ADDR_RX_CTRL: rd_byte[RXC_SERIAL_PORT_ENABLE] = st.serial_port_enable;
            ADDR_BAUD_CTRL: begin
                rd_byte[BAUD_POLARITY] = st.line_polarity_select;
                rd_byte[BAUD_WIDE] = st.wide;
            end
            ADDR_DIV_LO: rd_byte = st.div_lo;
            ADDR_DIV_HI: rd_byte = st.div_hi;
            ADDR_IRQ_CTRL: begin
                rd_byte[IRQC_GLOBAL] = st.global_irq_enable;
                rd_byte[IRQC_PERIPH] = st.peripheral_irq_enable;
                rd_byte[IRQC_TX_EN] = st.transmit_irq_enable;
                rd_byte[IRQC_TX_FLAG] = transmit_empty_flag; // [R17]
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Bus answer: one wait cycle, then pready for one cycle
        next_st.rsp.pready = access;
        next_st.rsp.pslverr = access & ~ast_mapped(apb_i.paddr);
        next_st.rsp.prdata = (access & ~apb_i.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

        // Baud generator restarts with each character so bit one is full length
        if (st.fsm == ST_IDLE) begin
            next_st.pre_cnt = 7'h00;
            next_st.div_cnt = divisor; // [R3]
        end else if (st.pre_cnt == pre_max - 7'h01) begin
            next_st.pre_cnt = 7'h00;
            next_st.div_cnt = (st.div_cnt == 16'h0000) ? divisor : st.div_cnt - 16'h0001;
        end else begin
            next_st.pre_cnt = st.pre_cnt + 7'h01;
        end

        // Frame sequencer
        case (st.fsm)
            ST_IDLE: begin
                if (st.hold_full) begin
                    next_st.shifter = {st.hold_ninth, st.hold_data}; // [R19]
                    next_st.nine_frame = st.tx_ctrl[TXC_NINE]; // [R19] [R6]
                    next_st.hold_full = 1'b0;
                    next_st.bit_cnt = 4'h0;
                    next_st.fsm = ST_START; // [R10] [R11]
                end
            end
            ST_START: begin
                if (tick) begin
                    next_st.fsm = ST_DATA; // [R2]
                end
            end
            ST_DATA: begin
                if (tick) begin
                    next_st.shifter = {1'b0, st.shifter[8:1]}; // [R4]
                    next_st.bit_cnt = st.bit_cnt + 4'h1;
                    if (last_data) begin
                        next_st.fsm = ST_STOP; // [R2] [R19]
                    end
                end
            end
            ST_STOP: begin
                if (tick) begin
                    next_st.fsm = ST_IDLE; // [R23]
                end
            end
            default: next_st.fsm = ST_IDLE;
        endcase

        // Register writes
        if (commit) begin
            case (apb_i.paddr)
                ADDR_TX_CTRL: begin
                    next_st.tx_ctrl = apb_i.pwdata[7:0];
                    next_st.tx_ctrl[TXC_SHIFT_EMPTY] = 1'b0;
                end
                ADDR_RX_CTRL: next_st.serial_port_enable = apb_i.pwdata[RXC_SERIAL_PORT_ENABLE];
                ADDR_BAUD_CTRL: begin
                    next_st.line_polarity_select = apb_i.pwdata[BAUD_POLARITY];
                    next_st.wide = apb_i.pwdata[BAUD_WIDE];
                end
                ADDR_DIV_LO: next_st.div_lo = apb_i.pwdata[7:0];
                ADDR_DIV_HI: next_st.div_hi = apb_i.pwdata[7:0];
                ADDR_HOLD: begin
                    // Written after any load above, so a character written in the cycle of a load is not lost
                    if (active) begin
                        next_st.hold_data = apb_i.pwdata[7:0];
                        next_st.hold_ninth = st.tx_ctrl[TXC_NINTH]; // [R19]
                        next_st.hold_full = 1'b1; // [R10] [R14]
                    end
                end
                ADDR_IRQ_CTRL: begin
                    next_st.global_irq_enable = apb_i.pwdata[IRQC_GLOBAL];
                    next_st.peripheral_irq_enable = apb_i.pwdata[IRQC_PERIPH];
                    next_st.transmit_irq_enable = apb_i.pwdata[IRQC_TX_EN];
                end
                default: next_st.serial_port_enable = st.serial_port_enable;
            endcase
        end

        // Leaving asynchronous transmit drops any frame and queued character
        if (!active) begin
            next_st.fsm = ST_IDLE; // [R7]
            next_st.hold_full = 1'b0; // [R16]
        end

        // Pin and request, from the values about to be registered
        case (next_st.fsm)
            ST_START: next_st.line = 1'b0;
            ST_DATA: next_st.line = next_st.shifter[0];
            default: next_st.line = 1'b1; // [R1] [R23]
        endcase
        next_st.line = next_st.line ^ next_st.line_polarity_select; // [R12]
        next_st.line_oe = next_st.serial_port_enable & next_st.tx_ctrl[TXC_EN]; // [R8] [R9]
        next_st.irq = next_st.tx_ctrl[TXC_EN] & ~next_st.hold_full & next_st.transmit_irq_enable
                      & next_st.peripheral_irq_enable & next_st.global_irq_enable; // [R17]
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.tx_ctrl <= TX_CTRL_RST;
            st.div_lo <= DIV_RST;
            st.div_hi <= DIV_RST;
            st.fsm <= ST_IDLE;
            st.line <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign apb_o = st.rsp;
    assign transmit_clock_pin_o = st.line;
    assign transmit_clock_pin_oe_o = st.line_oe;
    assign tx_irq_o = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b);

    // Counters stand in for long repetitions, which the tools would unroll
    logic [23:0] bit_clocks;
    logic [3:0] sent_bits;

    // Clocks since the current bit began, and data bits seen in this frame
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            bit_clocks <= 24'h000000;
            sent_bits <= 4'h0;
        end else begin
            bit_clocks <= (st.fsm == ST_IDLE || tick) ? 24'h000000 : bit_clocks + 24'h000001;
            if (st.fsm == ST_IDLE) begin
                sent_bits <= 4'h0;
            end else if (tick && st.fsm == ST_DATA) begin
                sent_bits <= sent_bits + 4'h1;
            end
        end
    end

    property p_idle_mark;
        (st.fsm == ST_IDLE) |-> (transmit_clock_pin_o == ~st.line_polarity_select);
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("line not at mark when idle"); // [R1]

    property p_start_space;
        (st.fsm == ST_START) |-> (transmit_clock_pin_o == st.line_polarity_select);
    endproperty
    a_start_space: assert property (p_start_space) else $error("start bit not space"); // [R2]

    property p_bit_length;
        (tick && st.fsm != ST_IDLE) |->
            ({8'h00, bit_clocks + 16'h0001} == {17'h00000, pre_max} * ({8'h00, divisor} + 24'h1));
    endproperty
    a_bit_length: assert property (p_bit_length) else $error("bit period wrong"); // [R3]

    property p_data_count;
        (st.fsm == ST_DATA && next_st.fsm == ST_STOP) |=>
            (sent_bits == (st.nine_frame ? 4'h9 : 4'h8));
    endproperty
    a_data_count: assert property (p_data_count) else $error("wrong number of data bits"); // [R19]

    property p_lsb_first;
        (st.fsm == ST_START && tick && active)
            |=> (transmit_clock_pin_o == ($past(st.shifter[0]) ^ st.line_polarity_select));
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first data bit not lsb"); // [R4]

    property p_load_idle;
        (commit && apb_i.paddr == ADDR_HOLD && active && shifter_empty_status && !st.hold_full)
            |=> ##1 (st.fsm == ST_START);
    endproperty
    a_load_idle: assert property (p_load_idle) else $error("idle shifter not loaded"); // [R10]

    property p_load_after_stop;
        (st.fsm == ST_STOP && tick && st.hold_full && active) |-> ##[1:4] (st.fsm == ST_START);
    endproperty
    a_load_after_stop: assert property (p_load_after_stop) else $error("queued char late"); // [R11]

    property p_flag_clears;
        (commit && apb_i.paddr == ADDR_HOLD && active && !shifter_empty_status)
            |-> ##[1:8] (!transmit_empty_flag && !tx_irq_o);
    endproperty
    a_flag_clears: assert property (p_flag_clears) else $error("empty flag stays set"); // [R14] [R15]

    property p_flag_on_enable;
        $rose(tx_en) |-> transmit_empty_flag;
    endproperty
    a_flag_on_enable: assert property (p_flag_on_enable) else $error("flag not set by enable"); // [R16]

    property p_irq_gate;
        tx_irq_o |-> (transmit_empty_flag && st.transmit_irq_enable && st.peripheral_irq_enable && st.global_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without all enables"); // [R17]

    property p_busy_status;
        (st.fsm == ST_DATA && active) |-> (shifter_empty_status == 1'b0) throughout ##1 (st.fsm != ST_IDLE);
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("status empty while busy"); // [R18]

    property p_pin_release;
        !(st.serial_port_enable && tx_en) |-> !transmit_clock_pin_oe_o;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin driven while off"); // [R9]

    property p_stop_quiet;
        !active |=> (st.fsm == ST_IDLE);
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("sending while disabled"); // [R7]

    // Line level in the stop and data states follows the state and the polarity bit
    property p_stop_mark;
        (st.fsm == ST_STOP) |-> (transmit_clock_pin_o == ~st.line_polarity_select);
    endproperty
    a_stop_mark: assert property (p_stop_mark) else $error("stop bit not mark"); // [R2]

    property p_data_bit;
        (st.fsm == ST_DATA) |-> (transmit_clock_pin_o == (st.shifter[0] ^ st.line_polarity_select));
    endproperty
    a_data_bit: assert property (p_data_bit) else $error("data bit not on line"); // [R4] [R12]

    property p_pin_drive;
        (st.serial_port_enable && tx_en) |-> transmit_clock_pin_oe_o;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin not driven"); // [R8]

    // A queued character must mark the shifter busy on the very next edge
    property p_status_load;
        (st.fsm == ST_IDLE && st.hold_full && active) |=> !shifter_empty_status;
    endproperty
    a_status_load: assert property (p_status_load) else $error("status empty after load"); // [R18]

    // Bus answer never stretches past one cycle
    property p_ready_pulse;
        apb_o.pready |=> !apb_o.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

    c_frame_eight: cover property ((st.fsm == ST_STOP) && !st.nine_frame && tick);
    c_frame_nine: cover property ((st.fsm == ST_STOP) && st.nine_frame && tick);
    c_back_to_back: cover property ((st.fsm == ST_STOP) && tick && st.hold_full);
    c_inverted: cover property ((st.fsm == ST_DATA) && st.line_polarity_select);
    c_irq: cover property ($rose(tx_irq_o));

endmodule
`default_nettype wire

//--- rtl/ast_pkg.sv
// Shared constants, types and helpers of the asynchronous serial transmitter
package ast_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
    localparam logic [7:0] ADDR_BAUD_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DIV_LO = 8'h0c;
    localparam logic [7:0] ADDR_DIV_HI = 8'h10;
    localparam logic [7:0] ADDR_HOLD = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h18;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int TXC_NINE = 6;
    localparam int TXC_EN = 5;
    localparam int TXC_SYNC = 4;
    localparam int TXC_HIGH_SPEED = 2;
    localparam int TXC_SHIFT_EMPTY = 1;
    localparam int TXC_NINTH = 0;
    localparam int RXC_SERIAL_PORT_ENABLE = 7;
    localparam int BAUD_POLARITY = 4;
    localparam int BAUD_WIDE = 3;
    localparam int IRQC_GLOBAL = 7;
    localparam int IRQC_PERIPH = 6;
    localparam int IRQC_TX_EN = 1;
    localparam int IRQC_TX_FLAG = 0;
    localparam logic [7:0] TX_CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TCY_NS = 80;
    localparam int TCY_CLOCKS = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] PRE_SLOW = 7'h40;
    localparam logic [6:0] PRE_MID = 7'h10;
    localparam logic [6:0] PRE_FAST = 7'h04;
    localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
    localparam logic [3:0] LAST_BIT_NINE = 4'h8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_DATA = 2'b10,
        ST_STOP = 2'b11
    } ast_fsm_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ast_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ast_apb_rsp_t;

    typedef struct packed {
        logic [7:0] tx_ctrl;
        logic serial_port_enable;
        logic line_polarity_select;
        logic wide;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic transmit_irq_enable;
        logic [7:0] hold_data;
        logic hold_ninth;
        logic hold_full;
        logic [8:0] shifter;
        logic [3:0] bit_cnt;
        logic nine_frame;
        ast_fsm_t fsm;
        logic [6:0] pre_cnt;
        logic [15:0] div_cnt;
        logic line;
        logic line_oe;
        logic irq;
        ast_apb_rsp_t rsp;
    } ast_state_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [6:0] ast_prescale(input logic wide, input logic high);
        case ({wide, high})
            2'b00: return PRE_SLOW;
            2'b11: return PRE_FAST;
            default: return PRE_MID;
        endcase
    endfunction

    function automatic logic [15:0] ast_divisor(input logic wide, input logic [7:0] lo,
                                                input logic [7:0] hi);
        return wide ? {hi, lo} : {8'h00, lo};
    endfunction

    function automatic logic ast_mapped(input logic [7:0] addr);
        return addr inside {ADDR_TX_CTRL, ADDR_RX_CTRL, ADDR_BAUD_CTRL, ADDR_DIV_LO,
                            ADDR_DIV_HI, ADDR_HOLD, ADDR_IRQ_CTRL};
    endfunction

endpackage

//--- bench/ast_rx_model.sv
// Remote asynchronous receiver listening on the transmit line
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model #(
    parameter int BIT_CLOCKS = 8
) (
    // Clock
    input wire logic clk_i,
    // Line and format
    input wire logic line_i,
    input wire logic invert_i,
    input wire logic nine_i,
    // Results
    output var logic [8:0] data_o,
    output var int count_o,
    output var int frame_err_o,
    output var int min_run_o,
    output var int gap_o
);
    logic lvl;
    int run;
    int idle;
    logic [8:0] sh;

    assign lvl = line_i ^ invert_i;

    // ------------------------------------------------------------------
    // Shortest space run
    // ------------------------------------------------------------------
    // Glitches of one or two clocks from a polarity change are not bits
    initial begin
        run = 0;
        min_run_o = 1000;
        forever begin
            @(posedge clk_i);
            if (lvl == 1'b0) begin
                run++;
            end else begin
                if (run >= 3 && run < min_run_o) min_run_o = run;
                run = 0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame sampling at mid-bit
    // ------------------------------------------------------------------
    initial begin
        data_o = '0;
        count_o = 0;
        frame_err_o = 0;
        gap_o = 0;
        idle = 0;
        forever begin
            @(posedge clk_i);
            if (lvl == 1'b1) begin
                idle++;
            end else begin
                gap_o = idle;
                idle = 0;
                repeat (BIT_CLOCKS / 2) @(posedge clk_i);
                if (lvl == 1'b0) begin
                    sh = '0;
                    for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
                        repeat (BIT_CLOCKS) @(posedge clk_i);
                        sh[i] = lvl;
                    end
                    repeat (BIT_CLOCKS) @(posedge clk_i);
                    if (lvl !== 1'b1) frame_err_o++;
                    data_o = sh;
                    count_o++;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/ast_transmitter_tb.sv
// Self-checking testbench of the asynchronous serial transmitter
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter_tb;
    import ast_pkg::*;
    // Prescale 4 with divisor 1 gives eight clocks a bit
    localparam int P = 8;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    ast_apb_req_t apb_i = '0;
    ast_apb_rsp_t apb_o;
    logic pin, pin_oe, irq;
    logic inv = 1'b0;
    logic nine = 1'b0;
    logic [8:0] rx_data;
    int rx_count, rx_ferr, min_run, gap;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] q;
    logic e;
    // Line has a pull-up while the pin is released
    wire logic line = pin_oe ? pin : 1'b1;

    always #10 clk_i = ~clk_i;

    ast_transmitter ast_transmitter_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .apb_i(apb_i),
        .apb_o(apb_o), .transmit_clock_pin_o(pin), .transmit_clock_pin_oe_o(pin_oe),
        .tx_irq_o(irq));
    ast_rx_model #(.BIT_CLOCKS(P)) ast_rx_model_i (.clk_i(clk_i), .line_i(line),
        .invert_i(inv), .nine_i(nine), .data_o(rx_data), .count_o(rx_count),
        .frame_err_o(rx_ferr), .min_run_o(min_run), .gap_o(gap));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic wr_en, input logic [7:0] d);
        @(posedge clk_i);
        apb_i.psel <= 1'b1;
        apb_i.penable <= 1'b0;
        apb_i.pwrite <= wr_en;
        apb_i.paddr <= a;
        apb_i.pwdata <= {24'h000000, d};
        apb_i.pstrb <= 4'hf;
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        do @(posedge clk_i); while (apb_o.pready !== 1'b1);
        q = apb_o.prdata;
        e = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
        apb(a, 1'b0, 8'h00);
        check(q, {24'h000000, exp}, msg);
    endtask

    task automatic wait_rx(input int n);
        repeat (400) begin
            if (rx_count >= n) break;
            @(posedge clk_i);
        end
        check(rx_count, n, "frames received");
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // A whole run needs under a thousand clocks
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        check(pin_oe, 1'b0, "pin driven after reset");
        rd(ADDR_TX_CTRL, 8'h02, "control after reset");
        rd(ADDR_IRQ_CTRL, 8'h00, "flag while disabled");
        apb(8'h1c, 1'b0, 8'h00);
        check(e, 1'b1, "unmapped access error");
        wr(ADDR_DIV_LO, 8'h01);
        rd(ADDR_DIV_LO, 8'h01, "divisor readback");
        wr(ADDR_BAUD_CTRL, 8'h08);
        wr(ADDR_RX_CTRL, 8'h80);
        wr(ADDR_TX_CTRL, 8'h24);
        @(posedge clk_i);
        check(pin_oe, 1'b1, "pin output");
        check(pin, 1'b1, "idle level");
        rd(ADDR_IRQ_CTRL, 8'h01, "flag after enable");
        // Second character waits behind the first
        wr(ADDR_HOLD, 8'h3c);
        wr(ADDR_HOLD, 8'ha5);
        repeat (2) @(posedge clk_i);
        rd(ADDR_IRQ_CTRL, 8'h00, "flag while queued");
        rd(ADDR_TX_CTRL, 8'h24, "shifter busy");
        wait_rx(1);
        check(rx_data, 9'h03c, "first character");
        wait_rx(2);
        check(rx_data, 9'h0a5, "queued character");
        check(gap <= P / 2 + TCY_CLOCKS, 1'b1, "gap after stop");
        check(min_run, P, "bit length");
        check(rx_ferr, 0, "stop bits");
        repeat (P) @(posedge clk_i);
        rd(ADDR_TX_CTRL, 8'h26, "shifter empty again");
        // Nine-bit character with the address marker
        wr(ADDR_TX_CTRL, 8'h65);
        nine <= 1'b1;
        wr(ADDR_HOLD, 8'h55);
        wait_rx(3);
        check(rx_data, 9'h155, "nine-bit character");
        repeat (P) @(posedge clk_i);
        // Inverted line
        wr(ADDR_TX_CTRL, 8'h24);
        nine <= 1'b0;
        wr(ADDR_BAUD_CTRL, 8'h18);
        inv <= 1'b1;
        repeat (2) @(posedge clk_i);
        check(pin, 1'b0, "inverted idle");
        wr(ADDR_HOLD, 8'h0f);
        wait_rx(4);
        check(rx_data, 9'h00f, "inverted character");
        repeat (P) @(posedge clk_i);
        wr(ADDR_BAUD_CTRL, 8'h08);
        inv <= 1'b0;
        // Interrupt request follows the flag and all enables
        wr(ADDR_IRQ_CTRL, 8'hc2);
        @(posedge clk_i);
        check(irq, 1'b1, "request raised");
        wr(ADDR_HOLD, 8'h81);
        wr(ADDR_HOLD, 8'h7e);
        repeat (2) @(posedge clk_i);
        check(irq, 1'b0, "request while queued");
        wait_rx(6);
        check(rx_data, 9'h07e, "last of burst");
        wr(ADDR_IRQ_CTRL, 8'h42);
        @(posedge clk_i);
        check(irq, 1'b0, "request without global enable");
        // Clocked mode and a disabled port refuse characters
        wr(ADDR_TX_CTRL, 8'h34);
        wr(ADDR_HOLD, 8'h11);
        repeat (12 * P) @(posedge clk_i);
        check(rx_count, 6, "clocked mode sends nothing");
        check(pin, 1'b1, "mark held");
        wr(ADDR_TX_CTRL, 8'h24);
        wr(ADDR_RX_CTRL, 8'h00);
        @(posedge clk_i);
        check(pin_oe, 1'b0, "pin released");
        wr(ADDR_HOLD, 8'h22);
        repeat (12 * P) @(posedge clk_i);
        check(rx_count, 6, "port off sends nothing");
        check(rx_ferr, 0, "no broken frames");
        tally_and_finish();
    end
endmodule
`default_nettype wire
